// File: logic/fbwg_consts.svh
// Purpose: offsets, field positions, reset values for the flash block write guard
// Assumes: 32-bit apb data, byte addresses
// Notes: definitions only
`ifndef FBWG_CONSTS_SVH
`define FBWG_CONSTS_SVH
`define FBWG_OFF_PROT_LOW 12'h600
`define FBWG_OFF_PROT_HIGH 12'h604
`define FBWG_OFF_DBG_OVR 12'h608
`define FBWG_OFF_RSVD 12'h60c
`define FBWG_OFF_IRQ_STAT 12'h610
`define FBWG_OFF_IRQ_EN 12'h614
`define FBWG_OFF_IRQ_CLR 12'h618
`define FBWG_OFF_LAST_ADDR 12'h61c
`define FBWG_BLOCK_SHIFT 12
`define FBWG_NUM_BLOCKS 48
`define FBWG_HIGH_BITS 16
`define FBWG_PROT_RST 32'h0000_0000
`define FBWG_DBG_OVR_RST 1'b1
`define FBWG_EVT_BLOCK 0
`define FBWG_EVT_FULL_CHIP_ERASE 1
`define FBWG_NUM_EVT 2
`endif

// File: logic/fbwg_pkg.sv
// Purpose: shared types of the flash block write guard
// Assumes: nothing beyond the constants header
// Notes: types only
package fbwg_pkg;
  typedef enum logic [1:0] {
    FBWG_OP_WRITE,
    FBWG_OP_PAGE_ERASE,
    FBWG_OP_FULL_ERASE
  } fbwg_op_t;

  typedef struct packed {
    logic valid;
    fbwg_op_t op;
    logic [31:0] addr;
  } fbwg_req_t;

  typedef struct packed {
    logic grant;
    logic fault;
  } fbwg_resp_t;
endpackage : fbwg_pkg

// File: logic/fbwg_checker.sv
// Purpose: combinational decision on one flash request against the protect map
// Assumes: request and map stable in the cycle they are sampled
// Notes: purely combinational; the top registers the result
`timescale 1ns/1ns
`include "fbwg_consts.svh"
module fbwg_checker
  import fbwg_pkg::*;
(
  // request and state
  input wire fbwg_req_t req,
  input wire logic [`FBWG_NUM_BLOCKS-1:0] prot_map,
  input wire logic guard_off,
  // decision
  output fbwg_resp_t resp,
  output logic full_erase_hit
);
  // block index of the target address; out-of-map addresses are never guarded for writes and page erases
  wire [19:0] blk_idx = req.addr[31:`FBWG_BLOCK_SHIFT];
  wire in_map = (blk_idx < 20'(`FBWG_NUM_BLOCKS));
  wire [5:0] blk_sel = blk_idx[5:0];
  wire blk_hit = in_map && prot_map[blk_sel];
  wire any_prot = |prot_map;
  wire is_full = (req.op == FBWG_OP_FULL_ERASE);
  wire hit = is_full ? any_prot : blk_hit;
  wire bad = req.valid && !guard_off && hit;
  assign resp.fault = bad;
  assign resp.grant = req.valid && !bad;
  assign full_erase_hit = bad && is_full;
endmodule : fbwg_checker

// File: logic/fbwg_top.sv
// Purpose: flash block write guard with apb register access
// Assumes: requests arrive as single-cycle valid pulses, synchronous to pclk
// Notes: grant/fault answered one cycle after the request
//
// Summary of operation
// - each protect bit covers one 4 kB block
// - write or erase to protected block faults
// - full erase with any protection faults
// - reset clears every protect bit
// - protect bits cannot be cleared by software
// - writing zero leaves a protect bit alone
// - guard off only in debug with override
// - override one means disabled, resets one
// - low register guards regions 0 to 31
// - high register bits 0-15 guard 32-47
`timescale 1ns/1ns
`include "fbwg_consts.svh"
module fbwg_top
  import fbwg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor flash requests
  input wire fbwg_req_t flash_req,
  input wire logic debug_mode,
  output fbwg_resp_t flash_resp_ff,
  // fault and interrupt
  output logic hard_fault_ff,
  output logic irq_ff
);
  // ==========================================================
  // registers
  logic [31:0] block_protect_low_ff;
  logic [`FBWG_HIGH_BITS-1:0] block_protect_high_ff;
  logic debug_protect_override_ff;
  logic [`FBWG_NUM_EVT-1:0] irq_stat_ff;
  logic [`FBWG_NUM_EVT-1:0] irq_en_ff;
  logic [31:0] last_addr_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  // ==========================================================
  // apb decode; zero wait states, so access phase completes at once
  function automatic logic hit_off(input logic [11:0] a, input logic [11:0] off);
    hit_off = (a == off);
  endfunction : hit_off

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sel_low = hit_off(paddr, `FBWG_OFF_PROT_LOW);
  wire sel_high = hit_off(paddr, `FBWG_OFF_PROT_HIGH);
  wire sel_dbg = hit_off(paddr, `FBWG_OFF_DBG_OVR);
  wire sel_rsvd = hit_off(paddr, `FBWG_OFF_RSVD);
  wire sel_stat = hit_off(paddr, `FBWG_OFF_IRQ_STAT);
  wire sel_en = hit_off(paddr, `FBWG_OFF_IRQ_EN);
  wire sel_clr = hit_off(paddr, `FBWG_OFF_IRQ_CLR);
  wire sel_last = hit_off(paddr, `FBWG_OFF_LAST_ADDR);
  wire mapped = sel_low || sel_high || sel_dbg || sel_rsvd || sel_stat || sel_en
    || sel_clr || sel_last;

  // ==========================================================
  // protect map: write-one-to-set, no clear path exists
  wire [31:0] nxt_block_protect_low = block_protect_low_ff
    | ((wr && sel_low) ? pwdata : 32'h0000_0000);
  wire [`FBWG_HIGH_BITS-1:0] nxt_block_protect_high = block_protect_high_ff
    | ((wr && sel_high) ? pwdata[`FBWG_HIGH_BITS-1:0] : 16'h0000);
  wire nxt_debug_protect_override = (wr && sel_dbg) ? pwdata[0] : debug_protect_override_ff;

  wire [`FBWG_NUM_BLOCKS-1:0] prot_map = {block_protect_high_ff, block_protect_low_ff};
  // 1 in the override means protection disabled while debugging
  wire guard_off = debug_mode && debug_protect_override_ff;

  // ==========================================================
  // request check
  fbwg_resp_t chk_resp;
  logic full_hit;
  fbwg_checker u_checker (
    .req(flash_req),
    .prot_map(prot_map),
    .guard_off(guard_off),
    .resp(chk_resp),
    .full_erase_hit(full_hit)
  );

  wire [`FBWG_NUM_EVT-1:0] evt = {full_hit, chk_resp.fault && !full_hit};
  wire [`FBWG_NUM_EVT-1:0] clr = (wr && sel_clr) ? pwdata[`FBWG_NUM_EVT-1:0] : 2'b00;
  // set beats clear when both land in one cycle
  wire [`FBWG_NUM_EVT-1:0] nxt_irq_stat = (irq_stat_ff & ~clr) | evt;
  wire [`FBWG_NUM_EVT-1:0] nxt_irq_en = (wr && sel_en) ? pwdata[`FBWG_NUM_EVT-1:0] : irq_en_ff;
  wire nxt_irq = |(nxt_irq_stat & nxt_irq_en);
  wire [31:0] nxt_last_addr = chk_resp.fault ? flash_req.addr : last_addr_ff;

  // ==========================================================
  // read mux; unused and reserved locations read zero
  wire [31:0] nxt_prdata =
      sel_low ? block_protect_low_ff
    : sel_high ? {16'h0000, block_protect_high_ff}
    : sel_dbg ? {31'h0000_0000, debug_protect_override_ff}
    : sel_stat ? {30'h0000_0000, irq_stat_ff}
    : sel_en ? {30'h0000_0000, irq_en_ff}
    : sel_last ? last_addr_ff
    : 32'h0000_0000;
  wire nxt_pslverr = !mapped;

  // ==========================================================
  // state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_protect_low_ff <= `FBWG_PROT_RST;
      block_protect_high_ff <= 16'h0000;
      debug_protect_override_ff <= `FBWG_DBG_OVR_RST;
      irq_stat_ff <= 2'b00;
      irq_en_ff <= 2'b00;
      last_addr_ff <= 32'h0000_0000;
    end else begin
      block_protect_low_ff <= nxt_block_protect_low;
      block_protect_high_ff <= nxt_block_protect_high;
      debug_protect_override_ff <= nxt_debug_protect_override;
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff <= nxt_irq_en;
      last_addr_ff <= nxt_last_addr;
    end
  end

  // answers to the processor: a faulted request is never granted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_resp_ff <= '0;
      hard_fault_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      flash_resp_ff <= chk_resp;
      hard_fault_ff <= chk_resp.fault;
      irq_ff <= nxt_irq;
    end
  end

  // apb read data captured in setup so it is ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff && acc;
  assign pready = 1'b1;
endmodule : fbwg_top

// File: tb/fbwg_assertions.sv
// Purpose: guard checks at the top ports
// Assumes: zero-wait apb
// Notes: keeps a shadow of the protect map
`timescale 1ns/1ns
module fbwg_assertions
  import fbwg_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // flash
  input wire fbwg_req_t flash_req,
  input wire logic debug_mode,
  input wire fbwg_resp_t flash_resp_ff,
  input wire logic hard_fault_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [47:0] map_ff;
  logic ovr_ff;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire on = !(debug_mode && ovr_ff);
  wire full = flash_req.op == FBWG_OP_FULL_ERASE;
  wire blk = flash_req.addr[31:12] < 20'h30 && map_ff[flash_req.addr[17:12]];
  wire hit = on && (full ? |map_ff : blk);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_ff <= '0;
      ovr_ff <= 1'b1;
    end else if (wr && paddr == 12'h600) begin
      map_ff[31:0] <= map_ff[31:0] | pwdata;
    end else if (wr && paddr == 12'h604) begin
      map_ff[47:32] <= map_ff[47:32] | pwdata[15:0];
    end else if (wr && paddr == 12'h608) begin
      ovr_ff <= pwdata[0];
    end
  end
  chk_fault_mirror: assert property (hard_fault_ff == flash_resp_ff.fault)
    else $error("mirror");
  chk_block_fault: assert property (flash_req.valid && hit |=> flash_resp_ff == 2'b01)
    else $error("fault");
  chk_grant_free: assert property (flash_req.valid && !hit |=> flash_resp_ff == 2'b10)
    else $error("grant");
  chk_idle_quiet: assert property (!flash_req.valid |=> flash_resp_ff == 2'b00)
    else $error("idle");
  chk_low_read: assert property (rd && paddr == 12'h600 |-> prdata == map_ff[31:0])
    else $error("low");
  chk_high_read: assert property (rd && paddr == 12'h604 |-> prdata == 32'(map_ff[47:32]))
    else $error("high");
  chk_override_read: assert property (rd && paddr == 12'h608 |-> prdata == 32'(ovr_ff))
    else $error("override");
  chk_reserved_read: assert property (rd && paddr == 12'h60c |-> prdata == 32'h0)
    else $error("reserved");
  cover property (flash_req.valid && hit);
  cover property (flash_req.valid && !on);
  cover property (wr && paddr == 12'h604);
endmodule : fbwg_assertions

// File: tb/fbwg_cpu_model.sv
// Purpose: processor side issuing flash requests
// Assumes: answer one cycle after the request edge
// Notes: a released address is inverted, never held
`timescale 1ns/1ns
module fbwg_cpu_model
  import fbwg_pkg::*;
(
  // flash port
  input wire logic pclk,
  output fbwg_req_t flash_req,
  input wire fbwg_resp_t flash_resp_ff
);
  initial flash_req = '0;
  task automatic issue(input fbwg_op_t op, input logic [31:0] a, output fbwg_resp_t r);
    @(posedge pclk);
    flash_req <= '{1'b1, op, a};
    @(posedge pclk);
    flash_req <= '{1'b0, op, ~a};
    @(posedge pclk);
    r = flash_resp_ff;
  endtask : issue
endmodule : fbwg_cpu_model

// File: tb/fbwg_top_test.sv
// Purpose: directed test of the flash block write guard
// Assumes: zero-wait apb, one-cycle flash answer
// Notes: a read passes its expected value in the data argument
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module fbwg_top_test
  import fbwg_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, debug_mode, pready, pslverr, hard_fault_ff, irq_ff;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  fbwg_req_t flash_req;
  fbwg_resp_t flash_resp_ff, r;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  fbwg_top i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .flash_req, .debug_mode, .flash_resp_ff, .hard_fault_ff, .irq_ff);
  fbwg_cpu_model i_cpu(.pclk, .flash_req, .flash_resp_ff);
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!w) `CHK("prdata", d, prdata)
    `CHK("pslverr", (a == 12'h700), pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic fl(input fbwg_op_t op, input logic [31:0] a, input logic e);
    i_cpu.issue(op, a, r);
    `CHK("flash_resp", {~e, e}, r)
  endtask : fl
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, debug_mode, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h600, 32'h0);
    apb(1'b0, 12'h608, 32'h1);
    fl(FBWG_OP_FULL_ERASE, 32'h0, 1'b0);
    apb(1'b1, 12'h600, 32'h8000_0001);
    apb(1'b1, 12'h604, 32'hffff_8001);
    apb(1'b1, 12'h600, 32'h0);
    apb(1'b1, 12'h60c, 32'hffff_ffff);
    apb(1'b0, 12'h600, 32'h8000_0001);
    apb(1'b0, 12'h604, 32'h8001);
    apb(1'b0, 12'h60c, 32'h0);
    fl(FBWG_OP_WRITE, 32'h0ffc, 1'b1);
    fl(FBWG_OP_WRITE, 32'h1000, 1'b0);
    fl(FBWG_OP_PAGE_ERASE, 32'h1_f000, 1'b1);
    fl(FBWG_OP_PAGE_ERASE, 32'h2_f000, 1'b1);
    fl(FBWG_OP_WRITE, 32'h2_e000, 1'b0);
    fl(FBWG_OP_FULL_ERASE, 32'h0, 1'b1);
    debug_mode <= 1'b1;
    fl(FBWG_OP_WRITE, 32'h0, 1'b0);
    apb(1'b1, 12'h608, 32'h0);
    fl(FBWG_OP_WRITE, 32'h0, 1'b1);
    apb(1'b1, 12'h608, 32'h1);
    debug_mode <= 1'b0;
    fl(FBWG_OP_WRITE, 32'h0, 1'b1);
    // interrupt: status sticky, clear, enable, mask
    apb(1'b0, 12'h610, 32'h3);
    apb(1'b1, 12'h618, 32'h3);
    apb(1'b1, 12'h614, 32'h1);
    `CHK("irq", 1'b0, irq_ff)
    fl(FBWG_OP_WRITE, 32'h0, 1'b1);
    `CHK("irq", 1'b1, irq_ff)
    apb(1'b1, 12'h614, 32'h0);
    apb(1'b0, 12'h610, 32'h1);
    apb(1'b0, 12'h614, 32'h0);
    `CHK("irq", 1'b0, irq_ff)
    // last faulting address follows the most recent refused request
    fl(FBWG_OP_PAGE_ERASE, 32'h2_f000, 1'b1);
    apb(1'b0, 12'h61c, 32'h0002_f000);
    apb(1'b0, 12'h700, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h604, 32'h0);
    fl(FBWG_OP_FULL_ERASE, 32'h0, 1'b0);
    end_of_test();
  end
endmodule : fbwg_top_test
bind fbwg_top fbwg_assertions i_chk(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .flash_req, .debug_mode, .flash_resp_ff, .hard_fault_ff);
